// File: logic/ialu_core.sv
// Integer execution datapath with Avalon-MM register access
//
// Operation
// - Operands come from general registers; results go to registers, flags, condition fields.
// - Reverse subtract computes second source minus first source.
// - Overflow sets sticky and result-exceed flags only when overflow check enabled.
// - Flag-updating instructions may run slowly or hold off the next one.
// - Compare zero-extends unsigned immediate, sign-extends signed immediate.
// - Plain compares are signed; logical compares are unsigned.
// - Compare result goes to the selected condition field, field zero by default.
// - Logical operations act on each bit independently.
// - Record logical forms and both AND-immediates update the first condition field.
// - Logical operations leave sticky, exceed and carry flags unchanged.
// - Rotate-then-AND writes rotated word ANDed with mask.
// - Rotate masks have begin and stop positions; count is immediate or register.
// - Immediate logical shifts are done through rotate with suitable masks.
// - Shift left, shift right, arithmetic right by register, arithmetic right by immediate.
// - Multiply high signed/unsigned, multiply low, signed and unsigned divide.
// - Count leading zeros, sign-extend byte and halfword.
// - Carrying and extended add/subtract, including minus-one and zero variants.
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ialu_consts.svh"
module ialu_core (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  import ialu_pkg::*;

  ialu_state_t state_q, state_d;
  ialu_op_t    op;
  logic [31:0] issue_q, issue_d, opnd_q, opnd_d, cond_q, cond_d, res_q, res_d;
  logic [31:0] rdata_d, rmux, bem, fmerge, rd_a, rd_b, a, b, signed_immediate, unsigned_immediate, mask;
  logic [4:0]  gidx_q, gidx_d, rt, ra, rb, rcount, mfirst, mstop, rot_n, rd_b_addr;
  logic [2:0]  crsel, sel;
  logic [15:0] imm;
  logic        wreq_d, sticky_q, sticky_d, exceed_q, exceed_d, carry_q, carry_d;
  logic        fresh_q, neg_q, neg_d, gwr_q, gwr_d, oe_eff, rec, acc, can, fin;
  logic        is_cmp, is_div, div_ov, div_go, div_done, alu_ovf, has_ov, sets_ca;
  logic        ca_new, cmp_signed, gwr, sticky_new, mem_we;
  logic [31:0] ax, ay, alu_res, cmp_y, dvd, dvs, quo, fin_res, lost, mem_wd, smul;
  logic [32:0] sum;
  logic [63:0] prod_s, prod_u, rot2;
  logic [5:0]  sra_amt;
  logic [3:0]  cmp_nib;

  assign op     = ialu_op_t'(issue_q[`IALU_F_OP]);
  assign rt     = issue_q[`IALU_F_RT];
  assign ra     = issue_q[`IALU_F_RA];
  assign rb     = issue_q[`IALU_F_RB];
  assign crsel  = issue_q[`IALU_F_CRF];
  assign imm    = opnd_q[`IALU_F_IMM];
  assign rcount = opnd_q[`IALU_F_RCNT];
  assign mfirst = opnd_q[`IALU_F_MFIRST];
  assign mstop  = opnd_q[`IALU_F_MSTOP];
  assign sel    = avs_address[`IALU_SEL_RANGE];
  assign bem    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Insert needs the old target word, so port B reads the target then
  assign rd_b_addr = (op == OP_RLWIMI) ? rt : rb;
  assign mem_we = (state_q == S_WB && gwr_q) || (acc && avs_write && sel == `IALU_SEL_GDATA);
  assign mem_wd = (state_q == S_WB) ? res_q : ((rd_a & ~bem) | (avs_writedata & bem));

  ialu_gpr_mem #(.W(32), .N(32)) u_greg (
    .core_clk  (core_clk),
    .rd_a_addr ((state_q == S_IDLE) ? gidx_q : ra),
    .rd_b_addr (rd_b_addr),
    .wr_en     (mem_we),
    .wr_addr   ((state_q == S_WB) ? rt : gidx_q),
    .wr_data   (mem_wd),
    .rd_a_q    (rd_a),
    .rd_b_q    (rd_b)
  );

  assign div_go = (state_q == S_EXEC) && is_div && !div_ov;

  ialu_divider #(.W(32)) u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (div_go),
    .dividend (dvd),
    .divisor  (dvs),
    .done_q   (div_done),
    .quo_q    (quo)
  );

  // Begin/stop positions count from the most significant bit
  for (genvar j = 0; j <= `IALU_MSB; j++)
  begin : g_mask
    localparam logic [4:0] POS = 5'(`IALU_MSB - j);
    assign mask[j] = (mfirst <= mstop) ? (POS >= mfirst && POS <= mstop)
                                       : (POS >= mfirst || POS <= mstop);
  end

  function automatic logic [31:0] lead_zeros(input logic [31:0] v);
    logic [31:0] n;
    logic        hit;
    n   = '0;
    hit = 1'b0;
    for (int i = `IALU_MSB; i >= 0; i--)
      if (!hit && !v[i])
        n = n + 32'h1;
      else
        hit = 1'b1;
    return n;
  endfunction

  // Operation datapath
  always_comb
  begin
    a       = ((op == OP_ADDI || op == OP_ADDIS) && ra == 5'h0) ? `IALU_ZERO : rd_a;
    b       = rd_b;
    signed_immediate    = {{16{imm[15]}}, imm};
    unsigned_immediate    = {`IALU_HALF_ZERO, imm};
    ax      = a;
    ay      = b;
    sum     = '0;
    has_ov  = 1'b0;
    sets_ca = 1'b0;
    is_cmp  = 1'b0;
    is_div  = 1'b0;
    gwr     = 1'b1;
    alu_ovf = 1'b0;
    ca_new  = carry_q;
    alu_res = `IALU_ZERO;
    // Reverse subtract: not(first) + second + 1 gives second minus first
    case (op)
      OP_SUBF, OP_SUBFC, OP_SUBFE, OP_SUBFME, OP_SUBFZE, OP_NEG, OP_SUBFIC: ax = ~a;
      default: ax = a;
    endcase
    case (op)
      OP_ADDI, OP_ADDIC, OP_SUBFIC: ay = signed_immediate;
      OP_ADDIS:                     ay = {imm, `IALU_HALF_ZERO};
      OP_ADDME, OP_SUBFME:          ay = `IALU_ONES;
      OP_ADDZE, OP_SUBFZE, OP_NEG:  ay = `IALU_ZERO;
      default:                      ay = b;
    endcase
    case (op)
      OP_ADDE, OP_SUBFE, OP_ADDME, OP_SUBFME, OP_ADDZE, OP_SUBFZE:
        sum = {1'b0, ax} + {1'b0, ay} + {32'h0, carry_q};
      OP_SUBF, OP_SUBFC, OP_SUBFIC, OP_NEG:
        sum = {1'b0, ax} + {1'b0, ay} + 33'h1;
      default:
        sum = {1'b0, ax} + {1'b0, ay};
    endcase
    smul    = (op == OP_MULLI) ? signed_immediate : b;
    // Both factors widened first, else the product is cut to 32 bits
    prod_s  = 64'($signed({{32{a[`IALU_MSB]}}, a}) * $signed({{32{smul[`IALU_MSB]}}, smul}));
    prod_u  = {32'h0, a} * {32'h0, b};
    rot_n   = (op == OP_RLWNM) ? b[4:0] : rcount;
    rot2    = {a, a} << rot_n;
    sra_amt = (op == OP_SRAWI) ? {1'b0, rcount} : b[5:0];
    lost    = sra_amt[5] ? `IALU_ONES : ~(`IALU_ONES << sra_amt[4:0]);
    cmp_signed = (op == OP_CMPI || op == OP_CMP);
    cmp_y   = (op == OP_CMPI) ? signed_immediate : ((op == OP_CMPLI) ? unsigned_immediate : b);
    div_ov  = (b == `IALU_ZERO) || (op == OP_DIVW && a == `IALU_MIN_INT && b == `IALU_ONES);
    neg_d   = (op == OP_DIVW) && (a[`IALU_MSB] ^ b[`IALU_MSB]);
    dvd     = (op == OP_DIVW && a[`IALU_MSB]) ? 32'(-a) : a;
    dvs     = (op == OP_DIVW && b[`IALU_MSB]) ? 32'(-b) : b;
    case (op)
      OP_ADD, OP_SUBF, OP_ADDI, OP_ADDIS, OP_ADDIC, OP_SUBFIC, OP_ADDC, OP_SUBFC, OP_ADDE,
      OP_SUBFE, OP_ADDME, OP_SUBFME, OP_ADDZE, OP_SUBFZE, OP_NEG:
      begin
        alu_res = sum[31:0];
        alu_ovf = (ax[`IALU_MSB] == ay[`IALU_MSB]) && (sum[`IALU_MSB] != ax[`IALU_MSB]);
        has_ov  = !(op == OP_ADDI || op == OP_ADDIS || op == OP_ADDIC || op == OP_SUBFIC);
        sets_ca = !(op == OP_ADD || op == OP_SUBF || op == OP_ADDI || op == OP_ADDIS
                    || op == OP_NEG);
        ca_new  = sum[32];
      end
      OP_MULLI, OP_MULLW:
      begin
        alu_res = prod_s[31:0];
        alu_ovf = prod_s[63:32] != {32{prod_s[`IALU_MSB]}};
        has_ov  = (op == OP_MULLW);
      end
      OP_MULHW:  alu_res = prod_s[63:32];
      OP_MULHWU: alu_res = prod_u[63:32];
      OP_DIVW, OP_DIVWU:
      begin
        is_div  = 1'b1;
        has_ov  = 1'b1;
        alu_ovf = div_ov;
      end
      OP_CMPI, OP_CMP, OP_CMPLI, OP_CMPL:
      begin
        is_cmp = 1'b1;
        gwr    = 1'b0;
      end
      OP_ANDI:   alu_res = a & unsigned_immediate;
      OP_ANDIS:  alu_res = a & {imm, `IALU_HALF_ZERO};
      OP_ORI:    alu_res = a | unsigned_immediate;
      OP_ORIS:   alu_res = a | {imm, `IALU_HALF_ZERO};
      OP_XORI:   alu_res = a ^ unsigned_immediate;
      OP_XORIS:  alu_res = a ^ {imm, `IALU_HALF_ZERO};
      OP_AND:    alu_res = a & b;
      OP_OR:     alu_res = a | b;
      OP_XOR:    alu_res = a ^ b;
      OP_NAND:   alu_res = ~(a & b);
      OP_NOR:    alu_res = ~(a | b);
      OP_EQV:    alu_res = ~(a ^ b);
      OP_ANDC:   alu_res = a & ~b;
      OP_ORC:    alu_res = a | ~b;
      OP_EXTSB:  alu_res = {{24{a[7]}}, a[7:0]};
      OP_EXTSH:  alu_res = {{16{a[15]}}, a[15:0]};
      OP_CNTLZW: alu_res = lead_zeros(a);
      OP_RLWINM, OP_RLWNM: alu_res = rot2[63:32] & mask;
      OP_RLWIMI: alu_res = (rot2[63:32] & mask) | (b & ~mask);
      // Immediate logical shifts have no op of their own; use rotate plus mask
      OP_SLW:    alu_res = b[5] ? `IALU_ZERO : (a << b[4:0]);
      OP_SRW:    alu_res = b[5] ? `IALU_ZERO : (a >> b[4:0]);
      OP_SRAWI, OP_SRAW:
      begin
        alu_res = sra_amt[5] ? {32{a[`IALU_MSB]}} : 32'($signed(a) >>> sra_amt[4:0]);
        sets_ca = 1'b1;
        ca_new  = a[`IALU_MSB] && ((a & lost) != `IALU_ZERO);
      end
      default:   gwr = 1'b0;
    endcase
    if (cmp_signed)
      cmp_nib = {$signed(a) < $signed(cmp_y), $signed(a) > $signed(cmp_y), a == cmp_y,
                 sticky_q};
    else
      cmp_nib = {a < cmp_y, a > cmp_y, a == cmp_y, sticky_q};
    oe_eff     = issue_q[`IALU_F_OE] && has_ov;
    rec        = issue_q[`IALU_F_RC] || op == OP_ANDI || op == OP_ANDIS;
    fin        = (state_q == S_EXEC && !div_go) || (state_q == S_DIV && div_done);
    fin_res    = (state_q == S_DIV) ? (neg_q ? 32'(-quo) : quo) : alu_res;
    sticky_new = sticky_q | (oe_eff & alu_ovf);
  end

  // Bus access: writes wait while an operation is in flight
  assign can = avs_write ? (state_q == S_IDLE)
             : (sel != `IALU_SEL_GDATA || (state_q == S_IDLE && fresh_q));
  assign acc = (avs_read || avs_write) && avs_waitrequest && can;
  assign fmerge = ({sticky_q, exceed_q, carry_q, 29'h0} & ~bem) | (avs_writedata & bem);

  always_comb
  begin
    case (sel)
      `IALU_SEL_ISSUE: rmux = issue_q;
      `IALU_SEL_OPND:  rmux = opnd_q;
      `IALU_SEL_FLAGS: rmux = {sticky_q, exceed_q, carry_q, 29'h0};
      `IALU_SEL_COND:  rmux = cond_q;
      `IALU_SEL_GIDX:  rmux = {27'h0, gidx_q};
      `IALU_SEL_GDATA: rmux = rd_a;
      `IALU_SEL_STAT:  rmux = {31'h0, state_q != S_IDLE};
      default:         rmux = `IALU_ZERO;
    endcase
  end

  always_comb
  begin
    state_d  = state_q;
    issue_d  = issue_q;
    opnd_d   = opnd_q;
    cond_d   = cond_q;
    gidx_d   = gidx_q;
    res_d    = res_q;
    gwr_d    = gwr_q;
    sticky_d = sticky_q;
    exceed_d = exceed_q;
    carry_d  = carry_q;
    wreq_d   = 1'b1;
    rdata_d  = avs_readdata;
    if (acc)
    begin
      wreq_d = 1'b0;
      if (avs_read)
        rdata_d = rmux;
      else
        case (sel)
          `IALU_SEL_ISSUE:
          begin
            issue_d = (issue_q & ~bem) | (avs_writedata & bem);
            state_d = S_FETCH;
          end
          `IALU_SEL_OPND: opnd_d = (opnd_q & ~bem) | (avs_writedata & bem);
          `IALU_SEL_COND: cond_d = (cond_q & ~bem) | (avs_writedata & bem);
          `IALU_SEL_GIDX: gidx_d = bem[0] ? avs_writedata[4:0] : gidx_q;
          `IALU_SEL_FLAGS:
          begin
            sticky_d = fmerge[`IALU_F_STICKY];
            exceed_d = fmerge[`IALU_F_EXCEED];
            carry_d  = fmerge[`IALU_F_CARRY];
          end
          default: ;
        endcase
    end
    case (state_q)
      S_FETCH: state_d = S_EXEC;
      S_EXEC:  state_d = div_go ? S_DIV : S_WB;
      S_DIV:   state_d = div_done ? S_WB : S_DIV;
      S_WB:    state_d = S_IDLE;
      S_IDLE:  ;
      default: state_d = S_IDLE;
    endcase
    if (fin)
    begin
      res_d = fin_res;
      gwr_d = gwr;
      if (oe_eff)
      begin
        exceed_d = alu_ovf;
        sticky_d = sticky_new;
      end
      if (sets_ca)
        carry_d = ca_new;
      if (is_cmp)
        cond_d[`IALU_CR_TOP - {crsel, 2'b00} -: 4] = cmp_nib;
      else if (rec)
        cond_d[`IALU_F_CR0] = {$signed(fin_res) < 0, $signed(fin_res) > 0,
                               fin_res == `IALU_ZERO, sticky_new};
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q         <= S_IDLE;
      issue_q         <= '0;
      opnd_q          <= '0;
      cond_q          <= '0;
      gidx_q          <= '0;
      res_q           <= '0;
      gwr_q           <= 1'b0;
      neg_q           <= 1'b0;
      fresh_q         <= 1'b0;
      sticky_q        <= 1'b0;
      exceed_q        <= 1'b0;
      carry_q         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end
    else
    begin
      state_q         <= state_d;
      issue_q         <= issue_d;
      opnd_q          <= opnd_d;
      cond_q          <= cond_d;
      gidx_q          <= gidx_d;
      res_q           <= res_d;
      gwr_q           <= gwr_d;
      neg_q           <= div_go ? neg_d : neg_q;
      fresh_q         <= (state_q == S_IDLE);
      sticky_q        <= sticky_d;
      exceed_q        <= exceed_d;
      carry_q         <= carry_d;
      avs_waitrequest <= wreq_d;
      avs_readdata    <= rdata_d;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  hold_off_a: assert property ((avs_write && state_q != S_IDLE) |=> avs_waitrequest)
    else $error("write accepted while busy");
  sub_order_a: assert property ((state_q == S_EXEC && op == OP_SUBF)
    |=> res_q == 32'($past(rd_b) - $past(rd_a)))
    else $error("reverse subtract order wrong");
  oe_gate_a: assert property ((fin && !oe_eff) |=> exceed_q == $past(exceed_q))
    else $error("exceed flag changed without check");
  sticky_set_a: assert property ((fin && oe_eff && alu_ovf) |=> sticky_q && exceed_q)
    else $error("overflow flags not set");
  cmp_unsigned_a: assert property ((fin && op == OP_CMPLI && crsel == 3'h0)
    |=> cond_q[`IALU_F_CR0] == {$past(rd_a) < $past(unsigned_immediate), $past(rd_a) > $past(unsigned_immediate),
        $past(rd_a) == $past(unsigned_immediate), $past(sticky_q)})
    else $error("unsigned compare field wrong");
  logic_flags_a: assert property ((fin && op >= OP_ANDI && op <= OP_CNTLZW)
    |=> $stable({sticky_q, exceed_q, carry_q}))
    else $error("logical op touched flags");
  insert_keep_a: assert property ((state_q == S_EXEC && op == OP_RLWIMI)
    |=> (res_q & ~$past(mask)) == ($past(rd_b) & ~$past(mask)))
    else $error("insert changed unmasked bits");
  and_mask_a: assert property ((state_q == S_EXEC && op == OP_RLWINM)
    |=> (res_q & ~$past(mask)) == `IALU_ZERO)
    else $error("rotate-and left bits outside mask");
  carry_in_a: assert property ((state_q == S_EXEC && op == OP_ADDE)
    |=> {carry_q, res_q} == {1'b0, $past(rd_a)} + {1'b0, $past(rd_b)} + 33'($past(carry_q)))
    else $error("extended add carry wrong");
  div_bound_a: assert property ($rose(state_q == S_DIV) |-> ##[32:34] (state_q == S_WB))
    else $error("divide did not finish in time");
  rec_field_a: assert property ((fin && rec && !is_cmp) |=> cond_q[`IALU_F_CR0] ==
    {$signed(res_q) < 0, $signed(res_q) > 0, res_q == `IALU_ZERO, sticky_q})
    else $error("record field wrong");

  div_run_c: cover property (state_q == S_DIV ##1 state_q == S_WB);
  cmp_field_c: cover property (fin && is_cmp && crsel != 3'h0);
  bus_stall_c: cover property (avs_write && !can);
endmodule // ialu_core

// File: logic/ialu_consts.svh
// Register offsets, field positions and constants of the integer datapath
`ifndef IALU_CONSTS_SVH
`define IALU_CONSTS_SVH
`define IALU_SEL_ISSUE  3'h0
`define IALU_SEL_OPND   3'h1
`define IALU_SEL_FLAGS  3'h2
`define IALU_SEL_COND   3'h3
`define IALU_SEL_GIDX   3'h4
`define IALU_SEL_GDATA  3'h5
`define IALU_SEL_STAT   3'h6
`define IALU_SEL_RANGE  4:2
`define IALU_F_OP       5:0
`define IALU_F_RC       6
`define IALU_F_OE       7
`define IALU_F_RT       12:8
`define IALU_F_RA       17:13
`define IALU_F_RB       22:18
`define IALU_F_CRF      25:23
`define IALU_F_IMM      15:0
`define IALU_F_RCNT     20:16
`define IALU_F_MFIRST   25:21
`define IALU_F_MSTOP    30:26
`define IALU_F_STICKY   31
`define IALU_F_EXCEED   30
`define IALU_F_CARRY    29
`define IALU_F_CR0      31:28
`define IALU_CR_TOP     5'h1F
`define IALU_MSB        31
`define IALU_ZERO       32'h0000_0000
`define IALU_ONES       32'hFFFF_FFFF
`define IALU_MIN_INT    32'h8000_0000
`define IALU_HALF_ZERO  16'h0000
`endif

// File: logic/ialu_pkg.sv
// Types shared by the integer datapath
package ialu_pkg;
  typedef enum logic [5:0] {
    OP_ADD, OP_ADDI, OP_ADDIS, OP_SUBF, OP_ADDIC, OP_SUBFIC, OP_ADDC, OP_SUBFC,
    OP_ADDE, OP_SUBFE, OP_ADDME, OP_SUBFME, OP_ADDZE, OP_SUBFZE, OP_NEG,
    OP_MULLI, OP_MULLW, OP_MULHW, OP_MULHWU, OP_DIVW, OP_DIVWU,
    OP_CMPI, OP_CMP, OP_CMPLI, OP_CMPL,
    OP_ANDI, OP_ANDIS, OP_ORI, OP_ORIS, OP_XORI, OP_XORIS, OP_AND, OP_OR, OP_XOR,
    OP_NAND, OP_NOR, OP_EQV, OP_ANDC, OP_ORC, OP_EXTSB, OP_EXTSH, OP_CNTLZW,
    OP_RLWINM, OP_RLWNM, OP_RLWIMI, OP_SLW, OP_SRW, OP_SRAWI, OP_SRAW
  } ialu_op_t;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_EXEC  = 3'b011,
    S_WB    = 3'b010,
    S_DIV   = 3'b110
  } ialu_state_t;
endpackage

// File: logic/ialu_gpr_mem.sv
// General register file: two registered read ports, one write port
`timescale 1ns/1ps
module ialu_gpr_mem #(
  parameter int W = 32,
  parameter int N = 32
) (
  input  wire logic                 core_clk,
  input  wire logic [$clog2(N)-1:0] rd_a_addr,
  input  wire logic [$clog2(N)-1:0] rd_b_addr,
  input  wire logic                 wr_en,
  input  wire logic [$clog2(N)-1:0] wr_addr,
  input  wire logic [W-1:0]         wr_data,
  output logic      [W-1:0]         rd_a_q,
  output logic      [W-1:0]         rd_b_q
);
  logic [W-1:0] mem_q [N];

  // Read before write; no reset, contents are software state
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      mem_q[wr_addr] <= wr_data;
    rd_a_q <= mem_q[rd_a_addr];
    rd_b_q <= mem_q[rd_b_addr];
  end
endmodule // ialu_gpr_mem

// File: logic/ialu_divider.sv
// Iterative unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module ialu_divider #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done_q,
  output logic      [W-1:0] quo_q
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0] rem_q, rem_d, dvs_q, dvs_d, quo_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          done_d;
  logic [W:0]    trial;

  always_comb
  begin
    rem_d  = rem_q;
    quo_d  = quo_q;
    dvs_d  = dvs_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    trial  = {rem_q, quo_q[W-1]};
    if (start)
    begin
      rem_d = '0;
      quo_d = dividend;
      dvs_d = divisor;
      cnt_d = CW'(W);
    end
    else if (cnt_q != '0)
    begin
      // Restore by not committing the subtraction
      if (trial >= {1'b0, dvs_q})
        rem_d = W'(trial - {1'b0, dvs_q});
      else
        rem_d = trial[W-1:0];
      quo_d  = {quo_q[W-2:0], trial >= {1'b0, dvs_q}};
      cnt_d  = cnt_q - CW'(1);
      done_d = (cnt_q == CW'(1));
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rem_q  <= '0;
      quo_q  <= '0;
      dvs_q  <= '0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      dvs_q  <= dvs_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end
endmodule // ialu_divider

// File: tb/ialu_host_model.sv
// Avalon-MM master model standing in for the dispatch logic
`timescale 1ns/1ps
module ialu_host_model (
  input  wire logic        core_clk,
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial
  begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  // Bounded wait, so a stuck slave is reported instead of hanging
  task automatic xfer(input logic w, input logic [2:0] sel, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge core_clk);
    avs_address <= {sel, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 300);
    ok = (avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Released data inverted so stale data never looks valid
    avs_writedata <= ~d;
  endtask
endmodule // ialu_host_model

// File: tb/tb.sv
// Self-checking bench for the integer datapath
`timescale 1ns/1ps
`include "ialu_consts.svh"
module tb;
  import ialu_pkg::*;
  logic        core_clk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rdv;
  logic        ok;
  int          failures;
  int          compares;
  ialu_core u_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ialu_host_model u_host (.core_clk(core_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  task automatic complete_run();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] sel, input logic [31:0] d);
    u_host.xfer(w, sel, d, rdv, ok);
    if (!ok)
    begin
      failures++;
      $display("[FAIL] %0t bus timeout", $time);
      complete_run();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic setreg(input logic [4:0] i, input logic [31:0] v);
    bus(1'b1, `IALU_SEL_GIDX, {27'h0, i});
    bus(1'b1, `IALU_SEL_GDATA, v);
  endtask
  // Source fixed at index 1, second source at 2
  task automatic op(input ialu_op_t o, input logic [4:0] rt, input logic rc, input logic oe,
                    input logic [2:0] crf, input logic [31:0] opnd);
    bus(1'b1, `IALU_SEL_OPND, opnd);
    bus(1'b1, `IALU_SEL_ISSUE, {6'h00, crf, 5'h02, 5'h01, rt, oe, rc, o});
  endtask
  // Index write stalls while busy, so this also waits for completion
  task automatic res(input logic [4:0] i, input logic [31:0] e);
    bus(1'b1, `IALU_SEL_GIDX, {27'h0, i});
    bus(1'b0, `IALU_SEL_GDATA, 32'h0);
    chk(rdv, e);
  endtask
  task automatic fl(input logic [31:0] e);
    bus(1'b0, `IALU_SEL_FLAGS, 32'h0);
    chk(rdv, e);
  endtask
  task automatic cr(input int n, input logic [3:0] e);
    bus(1'b0, `IALU_SEL_COND, 32'h0);
    chk({28'h0, rdv[31-4*n -: 4]}, {28'h0, e});
  endtask
  task automatic t_arith();
    setreg(5'h01, 32'h0000_0005);
    setreg(5'h02, 32'h0000_0003);
    op(OP_SUBF, 5'h03, 1'b0, 1'b0, 3'h0, 32'h0);
    res(5'h03, 32'hFFFF_FFFE);
    setreg(5'h01, 32'h7FFF_FFFF);
    setreg(5'h02, 32'h0000_0001);
    bus(1'b1, `IALU_SEL_FLAGS, 32'h0);
    op(OP_ADD, 5'h03, 1'b1, 1'b0, 3'h0, 32'h0);
    res(5'h03, 32'h8000_0000);
    fl(32'h0);
    op(OP_ADD, 5'h04, 1'b1, 1'b1, 3'h0, 32'h0);
    res(5'h04, 32'h8000_0000);
    fl(32'hC000_0000);
    cr(0, 4'h9);
    $display("Test arith done");
  endtask
  task automatic t_compare();
    setreg(5'h01, 32'hFFFF_FFFF);
    bus(1'b1, `IALU_SEL_FLAGS, 32'h0);
    op(OP_CMPI, 5'h00, 1'b0, 1'b0, 3'h3, 32'h0000_FFFF);
    op(OP_CMPLI, 5'h00, 1'b0, 1'b0, 3'h5, 32'h0000_FFFF);
    op(OP_CMP, 5'h00, 1'b0, 1'b0, 3'h0, 32'h0);
    res(5'h01, 32'hFFFF_FFFF);
    cr(3, 4'h2);
    cr(5, 4'h4);
    cr(0, 4'h8);
    $display("Test compare done");
  endtask
  task automatic t_logic();
    setreg(5'h01, 32'hF0F0_F0F0);
    setreg(5'h02, 32'hFF00_FF00);
    bus(1'b1, `IALU_SEL_FLAGS, 32'hE000_0000);
    op(OP_NAND, 5'h03, 1'b1, 1'b0, 3'h0, 32'h0);
    res(5'h03, 32'h0FFF_0FFF);
    fl(32'hE000_0000);
    cr(0, 4'h5);
    $display("Test logic done");
  endtask
  task automatic t_rotate();
    setreg(5'h01, 32'h1234_5678);
    setreg(5'h02, 32'hFFFF_FFFF);
    op(OP_RLWIMI, 5'h02, 1'b0, 1'b0, 3'h0, 32'h7F08_0000);
    res(5'h02, 32'hFFFF_FF12);
    op(OP_RLWINM, 5'h03, 1'b0, 1'b0, 3'h0, 32'h7F08_0000);
    res(5'h03, 32'h0000_0012);
    op(OP_RLWINM, 5'h03, 1'b0, 1'b0, 3'h0, 32'h7C9C_0000);
    res(5'h03, 32'h0123_4567);
    op(OP_SLW, 5'h03, 1'b0, 1'b0, 3'h0, 32'h0);
    res(5'h03, 32'h59E0_0000);
    $display("Test rotate done");
  endtask
  task automatic t_carry_div();
    setreg(5'h01, 32'hFFFF_FFFF);
    setreg(5'h02, 32'h0000_0000);
    bus(1'b1, `IALU_SEL_FLAGS, 32'h2000_0000);
    op(OP_ADDE, 5'h03, 1'b0, 1'b0, 3'h0, 32'h0);
    res(5'h03, 32'h0000_0000);
    fl(32'h2000_0000);
    setreg(5'h01, 32'h0000_0064);
    setreg(5'h02, 32'h0000_0007);
    op(OP_DIVWU, 5'h03, 1'b0, 1'b1, 3'h0, 32'h0);
    bus(1'b0, `IALU_SEL_STAT, 32'h0);
    chk({31'h0, rdv[0]}, 32'h1);
    res(5'h03, 32'h0000_000E);
    op(OP_CNTLZW, 5'h04, 1'b0, 1'b0, 3'h0, 32'h0);
    res(5'h04, 32'h0000_0019);
    setreg(5'h01, 32'h4000_0000);
    op(OP_MULHW, 5'h04, 1'b0, 1'b0, 3'h0, 32'h0);
    res(5'h04, 32'h0000_0001);
    $display("Test carry and divide done");
  endtask
  initial
  begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_arith();
    t_compare();
    t_logic();
    t_rotate();
    t_carry_div();
    complete_run();
  end
endmodule // tb
